// ==== design/cpu_memory_bus_access_consts.svh ====
// Operation
// - One bus access cycle is one clock
// - Beat count follows target and access width
// - Peripherals take byte, halfword and word accesses
// - Non-stacking word writes force top eight bits zero
// - Non-stacking word reads drop the top eight bits
// - Stacking words carry status over return address
// - Fetch and data run together when independent
// - Fetch stalls while shared memory serves data
// - Vector table base resets to 0x8000
// - RAM beyond size limit reads undefined
// - Debug area base: 24-bit address, top zero
// - Status mirror layout; upper byte reads zero
// - Protected flash reads undefined to debugger
// - Debugger program of protected flash rejected with error
// - Password unlocks; reset restores protection
// - Every target except DRAM does halfword in one cycle
// - Decoder spans full 24-bit address space
// - Status mirror writes have no effect
`ifndef CPU_MEMORY_BUS_ACCESS_CONSTS_SVH
`define CPU_MEMORY_BUS_ACCESS_CONSTS_SVH
// Memory map regions
`define IRAM_BASE        24'h000000
`define IRAM_SIZE        24'h002000
`define PERIPH_BASE      24'h004000
`define PERIPH_SIZE      24'h002000
`define DRAM_BASE        24'h006000
`define DRAM_SIZE        24'h000100
`define FLASH_BASE       24'h008000
`define FLASH_SIZE       24'h020000
// Debug work area is the last 64 bytes of RAM
`define DEBUG_AREA_SIZE  24'h000040
// Local register offsets
`define RAM_SIZE_OFS     24'h004002
`define VBASE_LO_OFS     24'h004004
`define VBASE_HI_OFS     24'h004006
`define STATUS_MIR_OFS   24'h004008
`define DBG_BASE_LO_OFS  24'h00400c
`define DBG_BASE_HI_OFS  24'h00400e
`define FLASH_WAIT_OFS   24'h0041b0
// Reset values
`define VBASE_RST        24'h008000
`define RAM_SIZE_RST     3'h0
`define FLASH_WAIT_RST   2'h3
// Status mirror field positions
`define MIR_IL_LSB       5
`define MIR_IE_BIT       4
// Value returned for undefined reads
`define UNDEF_DATA       32'h00000000
// Unlock password, arbitrary value
`define UNLOCK_PW        32'h5a3c_96e1
`endif

// ==== design/cpu_memory_bus_access_pkg.sv ====
package cpu_memory_bus_access_pkg;
  // Address region classes
  typedef enum logic [2:0] {
    REG_IRAM   = 3'b000,
    REG_PERIPH = 3'b001,
    REG_DRAM   = 3'b010,
    REG_FLASH  = 3'b011,
    REG_RSVD   = 3'b100
  } region_t;
  // Data access sequencer states
  typedef enum logic [1:0] {
    D_IDLE = 2'b00,
    D_BEAT = 2'b01,
    D_DONE = 2'b10
  } dstate_t;
endpackage

// ==== design/cpu_memory_bus_access.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "cpu_memory_bus_access_consts.svh"
module cpu_memory_bus_access (
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic        if_req,
  input  wire logic [23:0] if_addr,
  output logic             if_ready,
  output logic      [15:0] if_rdata,
  input  wire logic        d_req,
  input  wire logic        d_wr,
  input  wire logic [1:0]  d_size,
  input  wire logic [23:0] d_addr,
  input  wire logic [31:0] d_wdata,
  input  wire logic        d_stack,
  input  wire logic        d_dbg,
  output logic             d_ready,
  output logic      [31:0] d_rdata,
  output logic             d_err,
  output logic             ibus_en,
  output logic      [23:0] ibus_addr,
  input  wire logic [15:0] ibus_rdata,
  output logic             dbus_en,
  output logic             dbus_wr,
  output logic      [1:0]  dbus_size,
  output logic      [23:0] dbus_addr,
  output logic      [31:0] dbus_wdata,
  input  wire logic [31:0] dbus_rdata,
  input  wire logic [7:0]  cpu_psr,
  input  wire logic        unlock_strobe,
  input  wire logic [31:0] unlock_key,
  output logic             flash_protected,
  output logic      [23:0] vector_base
);

  ////////////////////////////////////////////////////////////////////////////
  // Decode helpers

  // Full 24-bit decode into regions
  function automatic cpu_memory_bus_access_pkg::region_t region_of(input logic [23:0] a);
    if (a < `IRAM_SIZE) region_of = cpu_memory_bus_access_pkg::REG_IRAM;
    else if (a >= `PERIPH_BASE && a < `PERIPH_BASE + `PERIPH_SIZE)
      region_of = cpu_memory_bus_access_pkg::REG_PERIPH;
    else if (a >= `DRAM_BASE && a < `DRAM_BASE + `DRAM_SIZE)
      region_of = cpu_memory_bus_access_pkg::REG_DRAM;
    else if (a >= `FLASH_BASE && a < `FLASH_BASE + `FLASH_SIZE)
      region_of = cpu_memory_bus_access_pkg::REG_FLASH;
    else region_of = cpu_memory_bus_access_pkg::REG_RSVD;
  endfunction

  // Target width as log2 of bytes; all but DRAM carry a halfword in one cycle
  function automatic logic [1:0] width_of(input cpu_memory_bus_access_pkg::region_t r);
    unique case (r)
      cpu_memory_bus_access_pkg::REG_DRAM: width_of = 2'd0;
      cpu_memory_bus_access_pkg::REG_IRAM: width_of = 2'd2;
      default:                             width_of = 2'd1;
    endcase
  endfunction

  // Shared-memory collision between fetch and data
  function automatic logic collides(input cpu_memory_bus_access_pkg::region_t fr,
                                    input cpu_memory_bus_access_pkg::region_t dr);
    logic fram;
    logic dram;
    fram = (fr == cpu_memory_bus_access_pkg::REG_IRAM) ||
           (fr == cpu_memory_bus_access_pkg::REG_DRAM);
    dram = (dr == cpu_memory_bus_access_pkg::REG_IRAM) ||
           (dr == cpu_memory_bus_access_pkg::REG_DRAM);
    collides = ((fr == cpu_memory_bus_access_pkg::REG_FLASH) &&
                ((dr == cpu_memory_bus_access_pkg::REG_FLASH) ||
                 (dr == cpu_memory_bus_access_pkg::REG_DRAM))) || (fram && dram);
  endfunction

  // Local register hit
  function automatic logic local_hit(input logic [23:0] a);
    logic [23:0] h;
    h = {a[23:1], 1'b0};
    local_hit = (h == `RAM_SIZE_OFS) || (h == `VBASE_LO_OFS) || (h == `VBASE_HI_OFS) ||
                (h == `STATUS_MIR_OFS) || (h == `DBG_BASE_LO_OFS) ||
                (h == `DBG_BASE_HI_OFS) || (h == `FLASH_WAIT_OFS);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // State

  localparam logic [23:0] DBG_BASE = `IRAM_SIZE - `DEBUG_AREA_SIZE; // Debug area start

  cpu_memory_bus_access_pkg::dstate_t dstate, next_dstate;   // Data sequencer
  logic [23:0] daddr,   next_daddr;                          // Latched address
  logic [1:0]  dsize,   next_dsize;                          // Latched size
  logic        dwr,     next_dwr;                            // Latched direction
  logic [31:0] dwdata,  next_dwdata;                         // Latched write word
  logic        dstack,  next_dstack;                         // Stacking access
  logic        ddbg,    next_ddbg;                           // Debugger access
  logic [1:0]  dbeat,   next_dbeat;                          // Current beat
  logic [2:0]  dnum,    next_dnum;                           // Beats in access
  logic [1:0]  dwait,   next_dwait;                          // Flash wait count
  logic [31:0] acc,     next_acc;                            // Read assembly
  logic        next_d_ready;                                 // Done pulse
  logic [31:0] next_d_rdata;                                 // Read result
  logic        next_d_err;                                   // Rejected access
  logic        next_protected;                               // Protection flag
  logic [2:0]  ram_size_limit, next_ram_size_limit;          // RAM limit field
  logic [1:0]  flash_read_wait_sel, next_flash_read_wait_sel; // Flash wait field
  logic [23:0] next_vector_base;                             // Vector base
  logic        idone,   next_idone;                          // Fetch done
  logic [1:0]  iwait,   next_iwait;                          // Fetch wait count
  logic [15:0] next_if_rdata;                                // Fetch word

  ////////////////////////////////////////////////////////////////////////////
  // Data path combinational

  cpu_memory_bus_access_pkg::region_t dreg, reqreg;   // Regions of latched and new
  logic [1:0]  wlog;       // Target width
  logic [1:0]  nlog;       // Bytes per beat, log2
  logic [23:0] baddr;      // Beat address
  logic [5:0]  bsh;        // Beat bit offset
  logic [31:0] wchunk;     // Beat write data
  logic [31:0] rsrc;       // Beat read source
  logic [31:0] rchunk;     // Beat read data, lane aligned
  logic [31:0] rmask;      // Bytes of this beat
  logic        is_local;   // Local register beat
  logic        flash_rd;   // Flash read beat
  logic        beat_last;  // Beat completes now
  logic        over_limit; // RAM beyond limit
  logic [15:0] local_rd;   // Local register read
  logic [1:0]  be;         // Local byte lanes
  logic        fconf;      // Fetch collides with data

  always_comb begin
    dreg     = region_of(daddr);
    reqreg   = region_of(d_addr);
    wlog     = width_of(dreg);
    nlog     = (dsize < wlog) ? dsize : wlog;
    baddr    = daddr + (24'(dbeat) << wlog);
    bsh      = 6'({4'h0, dbeat} << (3 + wlog));
    wchunk   = dwdata >> bsh;
    // Replicate narrow data over every lane
    if (nlog == 2'd0) wchunk = {4{wchunk[7:0]}};
    else if (nlog == 2'd1) wchunk = {2{wchunk[15:0]}};
    is_local = local_hit(baddr);
    flash_rd = (dreg == cpu_memory_bus_access_pkg::REG_FLASH) && !dwr;
    // Flash reads hold for the programmed wait count
    beat_last = !(flash_rd && (dwait < flash_read_wait_sel));
    // Local register read mux; status mirror top byte zero
    unique case ({baddr[23:1], 1'b0})
      `RAM_SIZE_OFS:    local_rd = {13'h0, ram_size_limit};
      `VBASE_LO_OFS:    local_rd = vector_base[15:0];
      `VBASE_HI_OFS:    local_rd = {8'h00, vector_base[23:16]};
      `STATUS_MIR_OFS:  local_rd = {8'h00, cpu_psr};
      `DBG_BASE_LO_OFS: local_rd = DBG_BASE[15:0];
      `DBG_BASE_HI_OFS: local_rd = {8'h00, DBG_BASE[23:16]};
      `FLASH_WAIT_OFS:  local_rd = {14'h0, flash_read_wait_sel};
      default:          local_rd = 16'h0000;
    endcase
    rsrc   = is_local ? {16'h0000, local_rd} : dbus_rdata;
    // Narrow access picks its lane inside the target word
    rchunk = (dsize < wlog) ? (rsrc >> {baddr[1:0] & ((2'd1 << wlog) - 2'd1), 3'b000}) : rsrc;
    rmask  = (nlog == 2'd0) ? 32'h0000_00ff : (nlog == 2'd1) ? 32'h0000_ffff : 32'hffff_ffff;
    be     = (dsize == 2'd0) ? (baddr[0] ? 2'b10 : 2'b01) : 2'b11;
    over_limit = (reqreg == cpu_memory_bus_access_pkg::REG_IRAM) &&
                 (d_addr >= (`IRAM_SIZE >> ram_size_limit));
    fconf  = (dstate == cpu_memory_bus_access_pkg::D_BEAT) && collides(region_of(if_addr), dreg);
  end

  // Target-side data bus drive
  always_comb begin
    dbus_en    = (dstate == cpu_memory_bus_access_pkg::D_BEAT) && !is_local;
    dbus_wr    = dwr;
    dbus_size  = dsize;
    dbus_addr  = baddr;
    dbus_wdata = wchunk;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Data sequencer next state

  always_comb begin
    next_dstate  = dstate;
    next_daddr   = daddr;
    next_dsize   = dsize;
    next_dwr     = dwr;
    next_dwdata  = dwdata;
    next_dstack  = dstack;
    next_ddbg    = ddbg;
    next_dbeat   = dbeat;
    next_dnum    = dnum;
    next_dwait   = dwait;
    next_acc     = acc;
    next_d_ready = 1'b0;
    next_d_rdata = d_rdata;
    next_d_err   = 1'b0;
    next_ram_size_limit      = ram_size_limit;
    next_flash_read_wait_sel = flash_read_wait_sel;
    next_vector_base         = vector_base;
    unique case (dstate)
      // Take a request
      cpu_memory_bus_access_pkg::D_IDLE: begin
        if (d_req) begin
          next_daddr  = d_addr;
          next_dsize  = d_size;
          next_dwr    = d_wr;
          // Plain word writes carry a zero top byte; stacking keeps status
          next_dwdata = (d_size == 2'd2 && !d_stack) ? {8'h00, d_wdata[23:0]} : d_wdata;
          next_dstack = d_stack;
          next_ddbg   = d_dbg;
          next_dbeat  = 2'd0;
          next_dwait  = 2'd0;
          next_acc    = 32'h0;
          next_dnum   = (d_size > width_of(reqreg)) ?
                        3'(3'd1 << (d_size - width_of(reqreg))) : 3'd1;
          if (d_dbg && d_wr && flash_protected &&
              reqreg == cpu_memory_bus_access_pkg::REG_FLASH) begin
            // Debugger programming of protected flash
            next_dstate  = cpu_memory_bus_access_pkg::D_DONE;
            next_d_ready = 1'b1;
            next_d_err   = 1'b1;
          end else if (over_limit || reqreg == cpu_memory_bus_access_pkg::REG_RSVD) begin
            // Reserved-like access, nothing forwarded
            next_dstate  = cpu_memory_bus_access_pkg::D_DONE;
            next_d_ready = 1'b1;
            next_d_rdata = `UNDEF_DATA;
          end else begin
            next_dstate = cpu_memory_bus_access_pkg::D_BEAT;
          end
        end
      end
      // One beat per clock, flash reads may wait
      cpu_memory_bus_access_pkg::D_BEAT: begin
        if (!beat_last) begin
          next_dwait = dwait + 2'd1;
        end else begin
          next_dwait = 2'd0;
          next_acc   = acc | ((rchunk & rmask) << bsh);
          // Local register writes; status mirror ignores writes
          if (dwr && is_local) begin
            unique case ({baddr[23:1], 1'b0})
              `RAM_SIZE_OFS: if (be[0]) next_ram_size_limit = wchunk[2:0];
              `FLASH_WAIT_OFS: if (be[0]) next_flash_read_wait_sel = wchunk[1:0];
              `VBASE_LO_OFS: begin
                if (be[0]) next_vector_base[7:0]  = wchunk[7:0];
                if (be[1]) next_vector_base[15:8] = wchunk[15:8];
              end
              `VBASE_HI_OFS: if (be[0]) next_vector_base[23:16] = wchunk[7:0];
              default: next_vector_base = vector_base;
            endcase
          end
          if ({1'b0, dbeat} == dnum - 3'd1) begin
            next_dstate  = cpu_memory_bus_access_pkg::D_DONE;
            next_d_ready = 1'b1;
            next_d_rdata = acc | ((rchunk & rmask) << bsh);
            if (dsize == 2'd2 && !dstack) next_d_rdata[31:24] = 8'h00;
            if (ddbg && flash_rd && flash_protected) next_d_rdata = `UNDEF_DATA;
          end else begin
            next_dbeat = dbeat + 2'd1;
          end
        end
      end
      // Answer stands one cycle
      cpu_memory_bus_access_pkg::D_DONE: begin
        next_dstate = cpu_memory_bus_access_pkg::D_IDLE;
      end
      default: next_dstate = cpu_memory_bus_access_pkg::D_IDLE;
    endcase
    // Correct password clears protection; only reset sets it
    next_protected = flash_protected && !(unlock_strobe && unlock_key == `UNLOCK_PW);
  end

  // Data sequencer registers
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      dstate  <= cpu_memory_bus_access_pkg::D_IDLE;
      daddr   <= 24'h0;
      dsize   <= 2'h0;
      dwr     <= 1'b0;
      dwdata  <= 32'h0;
      dstack  <= 1'b0;
      ddbg    <= 1'b0;
      dbeat   <= 2'h0;
      dnum    <= 3'h1;
      dwait   <= 2'h0;
      acc     <= 32'h0;
      d_ready <= 1'b0;
      d_rdata <= 32'h0;
      d_err   <= 1'b0;
      flash_protected     <= 1'b1;
      ram_size_limit      <= `RAM_SIZE_RST;
      flash_read_wait_sel <= `FLASH_WAIT_RST;
      vector_base         <= `VBASE_RST;
    end else begin
      dstate  <= next_dstate;
      daddr   <= next_daddr;
      dsize   <= next_dsize;
      dwr     <= next_dwr;
      dwdata  <= next_dwdata;
      dstack  <= next_dstack;
      ddbg    <= next_ddbg;
      dbeat   <= next_dbeat;
      dnum    <= next_dnum;
      dwait   <= next_dwait;
      acc     <= next_acc;
      d_ready <= next_d_ready;
      d_rdata <= next_d_rdata;
      d_err   <= next_d_err;
      flash_protected     <= next_protected;
      ram_size_limit      <= next_ram_size_limit;
      flash_read_wait_sel <= next_flash_read_wait_sel;
      vector_base         <= next_vector_base;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Instruction fetch

  logic ifl_last; // Fetch word returns now

  // Fetch runs beside data unless memory is shared
  always_comb begin
    ibus_addr = if_addr;
    ibus_en   = if_req && !idone && !fconf;
    ifl_last  = ibus_en && !((region_of(if_addr) == cpu_memory_bus_access_pkg::REG_FLASH) &&
                             (iwait < flash_read_wait_sel));
    next_idone    = ifl_last;
    next_if_rdata = ifl_last ? ibus_rdata : if_rdata;
    next_iwait    = (ibus_en && !ifl_last) ? iwait + 2'd1 : (fconf ? iwait : 2'd0);
  end

  // Fetch registers
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      idone    <= 1'b0;
      iwait    <= 2'h0;
      if_rdata <= 16'h0;
    end else begin
      idone    <= next_idone;
      iwait    <= next_iwait;
      if_rdata <= next_if_rdata;
    end
  end

  assign if_ready = idone;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  prot_reject_a: assert property (
    dstate == cpu_memory_bus_access_pkg::D_IDLE && d_req && d_dbg && d_wr && flash_protected &&
    reqreg == cpu_memory_bus_access_pkg::REG_FLASH |=> d_ready && d_err && !dbus_en ##1 !dbus_en)
    else $error("protected flash program not rejected");
  word_write_top_a: assert property (
    dbus_en && dbus_wr && dsize == 2'd2 && !dstack && wlog == 2'd2 |-> dbus_wdata[31:24] == 8'h00)
    else $error("word write top byte not zero");
  word_read_top_a: assert property (
    d_ready && dsize == 2'd2 && !dstack |-> d_rdata[31:24] == 8'h00)
    else $error("word read top byte not dropped");
  byte_target_beats_a: assert property (
    dstate == cpu_memory_bus_access_pkg::D_IDLE && d_req && d_size == 2'd2 &&
    reqreg == cpu_memory_bus_access_pkg::REG_DRAM |=> dbus_en [*4] ##1 d_ready)
    else $error("byte target word access not four beats");
  fetch_stall_a: assert property (
    fconf |-> !ibus_en)
    else $error("fetch not stalled on shared memory");
  fetch_parallel_a: assert property (
    if_req && !idone && dstate == cpu_memory_bus_access_pkg::D_BEAT && !fconf |-> ibus_en)
    else $error("independent fetch held back");
  unlock_clears_a: assert property (
    unlock_strobe && unlock_key == `UNLOCK_PW |=> !flash_protected ##1 !flash_protected)
    else $error("password did not unlock");
  protect_hold_a: assert property (
    $fell(flash_protected) |-> $past(unlock_strobe) && $past(unlock_key) == `UNLOCK_PW)
    else $error("protection dropped without password");
  ram_limit_a: assert property (
    dstate == cpu_memory_bus_access_pkg::D_IDLE && d_req && over_limit |=> d_ready && !dbus_en)
    else $error("over-limit RAM access forwarded");

  word_iram_c: cover property (d_ready && dsize == 2'd2 && dreg == cpu_memory_bus_access_pkg::REG_IRAM);
  fetch_stall_c: cover property (if_req && fconf ##1 if_req && fconf);
  unlock_c: cover property ($fell(flash_protected));
  flash_wait_c: cover property (dbus_en && flash_rd && !beat_last);

endmodule
`default_nettype wire

// ==== dv/bus_target_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// Memory and peripheral side: answers every beat in its own cycle
module bus_target_model (
  input  wire logic        ref_clk,
  input  wire logic        ibus_en,
  input  wire logic [23:0] ibus_addr,
  output logic      [15:0] ibus_rdata,
  input  wire logic        dbus_en,
  input  wire logic        dbus_wr,
  input  wire logic [23:0] dbus_addr,
  input  wire logic [31:0] dbus_wdata,
  output logic      [31:0] dbus_rdata,
  output int               n_beats,
  output logic      [31:0] last_wdata
);
  logic [31:0] iw;                // Fetch word at the address
  logic [31:0] dw;                // Data word at the address
  logic [15:0] ilast = 16'h0000;  // Last fetch word driven
  logic [31:0] dlast = 32'h0000;  // Last data word driven
  logic        dseen = 1'b0;      // Data bus was up last cycle
  logic [23:0] dprev = 24'h0;     // Data address seen last cycle
  initial n_beats = 0;
  // Contents follow the address so any beat can be predicted
  function automatic logic [31:0] mem_word(logic [23:0] a);
    return {8'h9c, a[7:0] ^ 8'h77, a[15:8], a[7:0]};
  endfunction
  assign iw = mem_word(ibus_addr);
  assign dw = mem_word(dbus_addr);
  // Released buses show the inverse of their last value
  assign ibus_rdata = ibus_en ? iw[15:0] : ~ilast;
  assign dbus_rdata = dbus_en ? dw : ~dlast;
  // Count beats and keep the last write data
  always @(posedge ref_clk) begin
    if (ibus_en) begin
      ilast <= iw[15:0];
    end
    if (dbus_en) begin
      dlast <= dw;
      // Flash wait cycles hold the beat address; count each beat once
      if (!dseen || dbus_addr != dprev) begin
        n_beats <= n_beats + 1;
      end
      if (dbus_wr) begin
        last_wdata <= dbus_wdata;
      end
    end
    dseen <= dbus_en;
    dprev <= dbus_addr;
  end
endmodule
`default_nettype wire

// ==== dv/cpu_memory_bus_access_test.sv ====
`timescale 1ns/1ps
`default_nettype none
module cpu_memory_bus_access_test;
  logic ref_clk = 1'h0, rst_n = 1'h0, if_req = 1'h0, d_req = 1'h0, d_wr = 1'h0;
  logic d_stack = 1'h0, d_dbg = 1'h0, unlock_strobe = 1'h0;
  logic [1:0]  d_size = 2'h0;
  logic [23:0] if_addr = 24'h0, d_addr = 24'h0;
  logic [31:0] d_wdata = 32'h0, unlock_key = 32'h0;
  logic [7:0]  cpu_psr = 8'hb5;
  logic if_ready, d_ready, d_err, ibus_en, dbus_en, dbus_wr, flash_protected;
  logic [15:0] if_rdata, ibus_rdata;
  logic [1:0]  dbus_size;
  logic [23:0] ibus_addr, dbus_addr, vector_base;
  logic [31:0] d_rdata, dbus_wdata, dbus_rdata, last_wdata, rd;
  logic        er;
  int n_errors = 0, n_compared = 0, cycles = 0, nb, n_beats, n;
  // Ordinary transfers: access, address, target width, beats
  typedef struct {logic wr; logic [1:0] sz; logic [23:0] a; int bw; int beats;} row_t;
  row_t rows[11] = '{'{1'h0, 2'h1, 24'h4200, 2, 1}, '{1'h0, 2'h2, 24'h4100, 2, 2},
    '{1'h0, 2'h1, 24'h0100, 4, 1}, '{1'h0, 2'h2, 24'h0200, 4, 1},
    '{1'h0, 2'h0, 24'h6020, 1, 1}, '{1'h0, 2'h1, 24'h6030, 1, 2},
    '{1'h0, 2'h2, 24'h6010, 1, 4}, '{1'h0, 2'h1, 24'h8100, 2, 1},
    '{1'h0, 2'h2, 24'h027ffc, 2, 2}, '{1'h1, 2'h2, 24'h4104, 2, 2},
    '{1'h1, 2'h2, 24'h0300, 4, 1}};
  cpu_memory_bus_access i_cpu_memory_bus_access (.ref_clk, .rst_n, .if_req, .if_addr,
    .if_ready, .if_rdata, .d_req, .d_wr, .d_size, .d_addr, .d_wdata, .d_stack, .d_dbg,
    .d_ready, .d_rdata, .d_err, .ibus_en, .ibus_addr, .ibus_rdata, .dbus_en, .dbus_wr,
    .dbus_size, .dbus_addr, .dbus_wdata, .dbus_rdata, .cpu_psr, .unlock_strobe,
    .unlock_key, .flash_protected, .vector_base);
  bus_target_model i_bus_target_model (.ref_clk, .ibus_en, .ibus_addr, .ibus_rdata,
    .dbus_en, .dbus_wr, .dbus_addr, .dbus_wdata, .dbus_rdata, .n_beats, .last_wdata);
  always #12.5 ref_clk = ~ref_clk;
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] mem_word(logic [23:0] a);
    return {8'h9c, a[7:0] ^ 8'h77, a[15:8], a[7:0]};
  endfunction
  // Little-endian assembly over beats, top byte dropped on words
  function automatic logic [31:0] exp_rd(logic [23:0] a, logic [1:0] sz, int bw);
    logic [31:0] r, w;
    r = 32'h0;
    for (int k = 0; k < (1 << sz); k++) begin
      w = mem_word(a + 24'((k / bw) * bw));
      r[k*8 +: 8] = w[(k % bw)*8 +: 8];
    end
    if (sz == 2'h2) r[31:24] = 8'h00;
    return r;
  endfunction
  task automatic check(logic [31:0] got, logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // One data transfer, request held until done is seen
  task automatic access(logic wr, logic [1:0] sz, logic [23:0] a, logic [31:0] wd,
                        logic stk = 1'h0, logic dbg = 1'h0);
    int b0;
    @(posedge ref_clk);
    #1;
    {d_req, d_wr, d_size, d_addr, d_wdata, d_stack, d_dbg} = {1'h1, wr, sz, a, wd, stk, dbg};
    b0 = n_beats;
    for (int k = 0; k < 40 && d_ready !== 1'h1; k++) begin
      @(posedge ref_clk);
      #1;
    end
    {rd, er, nb, d_req} = {d_rdata, d_err, n_beats - b0, 1'h0};
  endtask
  task automatic fetch(logic [23:0] a, output int cnt);
    logic [31:0] w;
    w = mem_word(a);
    @(posedge ref_clk);
    #1;
    {if_req, if_addr} = {1'h1, a};
    for (cnt = 1; cnt < 40; cnt++) begin
      @(posedge ref_clk);
      #1;
      if (if_ready === 1'h1) break;
    end
    check(if_rdata, w[15:0]);
    if_req = 1'h0;
  endtask
  task automatic unlock(logic [31:0] key);
    @(posedge ref_clk);
    #1;
    {unlock_strobe, unlock_key} = {1'h1, key};
    @(posedge ref_clk);
    #1;
    unlock_strobe = 1'h0;
  endtask
  task automatic do_reset();
    rst_n = 1'h0;
    repeat (8) @(posedge ref_clk);
    #1;
    rst_n = 1'h1;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Hang guard
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 6000) begin
      n_errors++;
      tally_and_finish();
    end
  end
  // Fetch and data never share flash or the RAMs in one cycle
  always @(posedge ref_clk) begin
    if (ibus_en && dbus_en && ((ibus_addr >= 24'h8000 && (dbus_addr >= 24'h8000 ||
        dbus_addr[23:8] == 16'h0060)) || ((ibus_addr < 24'h2000 || ibus_addr[23:8] ==
        16'h0060) && (dbus_addr < 24'h2000 || dbus_addr[23:8] == 16'h0060)))) begin
      n_errors++;
      $display("BAD %0t fetch and data collide", $time);
    end
  end
  // Beat size always follows the access size
  always @(posedge ref_clk) begin
    if (dbus_en && dbus_size !== d_size) begin
      n_errors++;
      $display("BAD %0t beat size %0d", $time, dbus_size);
    end
  end
  initial begin
    do_reset();
    check(flash_protected, 32'h1);
    check(vector_base, 32'h8000);
    // Debug work area at the top of RAM stays untouched throughout
    foreach (rows[i]) begin
      access(rows[i].wr, rows[i].sz, rows[i].a, 32'hab12_3456);
      check(nb, rows[i].beats);
      if (rows[i].wr) check(last_wdata[31:24], 32'h0);
      else check(rd, exp_rd(rows[i].a, rows[i].sz, rows[i].bw));
    end
    access(1'h0, 2'h1, 24'h4004, 32'h0);
    check(rd, 32'h8000);
    access(1'h1, 2'h1, 24'h4008, 32'h0);
    access(1'h0, 2'h1, 24'h4008, 32'h0);
    check(rd, 32'h00b5);
    access(1'h0, 2'h2, 24'h400c, 32'h0);
    check(rd, 32'h1fc0);
    access(1'h0, 2'h1, 24'h41b0, 32'h0);
    check(rd[1:0], 32'h3);
    access(1'h1, 2'h2, 24'h0300, 32'hb500_1234, 1'h1);
    check(last_wdata, 32'hb500_1234);
    access(1'h0, 2'h2, 24'h0200, 32'h0, 1'h1);
    check(rd, mem_word(24'h0200));
    access(1'h0, 2'h1, 24'h8100, 32'h0, 1'h0, 1'h1);
    check(rd, 32'h0);
    access(1'h1, 2'h1, 24'h8100, 32'h1, 1'h0, 1'h1);
    check({er, 8'(nb)}, 32'h100);
    unlock(32'h5a3c_96e0);
    check(flash_protected, 32'h1);
    unlock(32'h5a3c_96e1);
    check(flash_protected, 32'h0);
    access(1'h0, 2'h1, 24'h8100, 32'h0, 1'h0, 1'h1);
    check(rd, exp_rd(24'h8100, 2'h1, 2));
    do_reset();
    check(flash_protected, 32'h1);
    access(1'h1, 2'h1, 24'h4002, 32'h1);
    access(1'h0, 2'h2, 24'h1800, 32'h0);
    check(rd, 32'h0);
    check(nb, 32'h0);
    access(1'h0, 2'h2, 24'h0800, 32'h0);
    check(rd, exp_rd(24'h0800, 2'h2, 4));
    access(1'h0, 2'h1, 24'h7000, 32'h0);
    check(rd, 32'h0);
    check(nb, 32'h0);
    access(1'h1, 2'h1, 24'h4002, 32'h0);
    // Fetch starts one cycle late so it overlaps a data beat
    fork
      begin
        @(posedge ref_clk);
        fetch(24'h0040, n);
      end
      access(1'h0, 2'h2, 24'h4100, 32'h0);
    join
    check(n, 32'h1);
    fork
      fetch(24'h8000, n);
      access(1'h0, 2'h2, 24'h6010, 32'h0);
    join
    check(rd, exp_rd(24'h6010, 2'h2, 1));
    // Four flash fetch cycles stretched by four byte beats
    check(n, 32'h8);
    tally_and_finish();
  end
endmodule
`default_nettype wire
